// File: ttc_pkg.sv
// ttc_pkg: register indices, field positions, reset values and mode codes
// for the three-timer counter unit.
// assumes: registers sit on APB at byte address = 4 * index.
package ttc_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] IDX_TIMER_MODE = 8'h89;
  localparam logic [7:0] IDX_T0_LOW = 8'h8A;
  localparam logic [7:0] IDX_T1_LOW = 8'h8B;
  localparam logic [7:0] IDX_T0_HIGH = 8'h8C;
  localparam logic [7:0] IDX_T1_HIGH = 8'h8D;
  localparam logic [7:0] IDX_T2_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] IDX_T2_LOW = 8'hCC;
  localparam logic [7:0] IDX_T2_HIGH = 8'hCD;

  // ==========================================================================
  // timer control register bit positions
  localparam int TC_T1_OVF = 7;
  localparam int TC_T1_RUN = 6;
  localparam int TC_T0_OVF = 5;
  localparam int TC_T0_RUN = 4;

  // timer mode register: per-timer nibble, timer 1 in the upper one
  localparam int TM_T1_LSB = 4;
  localparam int TM_T0_LSB = 0;
  localparam int TM_QUALIFY = 3;
  localparam int TM_SOURCE = 2;
  localparam int TM_MODE_HI = 1;
  localparam int TM_MODE_LO = 0;

  // timer 2 control bit positions
  localparam int T2_OVF = 7;
  localparam int T2_EXT = 6;
  localparam int T2_RX_SEL = 5;
  localparam int T2_TX_SEL = 4;
  localparam int T2_TRIG_EN = 3;
  localparam int T2_RUN = 2;
  localparam int T2_SOURCE = 1;
  localparam int T2_CAPTURE = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_TIMER_MODE = 8'h00;
  localparam logic [7:0] RST_T2_CONTROL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // ==========================================================================
  // synchronised pin positions
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_T2 = 2;
  localparam int PIN_TRIG = 3;
  localparam int PIN_LVL0 = 4;
  localparam int PIN_LVL1 = 5;
  localparam int PIN_N = 6;

  typedef enum logic [1:0] {
    TTC_MODE_13BIT = 2'b00,
    TTC_MODE_16BIT = 2'b01,
    TTC_MODE_RELOAD = 2'b10,
    TTC_MODE_SPLIT = 2'b11
  } ttc_mode_t;

endpackage : ttc_pkg

// File: ttc_three_timer_counter_unit.sv
// ttc_three_timer_counter_unit: timers 0, 1 and 2 with an APB register slave.
// assumes: APB master on SYS_CLK; count, trigger and level pins are
// asynchronous; vector acknowledges come from the core on SYS_CLK.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// R1: mode 0 counts thirteen bits: high byte plus low five bits of low byte.
// R2: wrap from all ones to zero sets the timer's overflow flag.
// R3: timer 0/1 counts while run is set and qualify clear or level high.
// R4: setting run never clears the count bytes.
// R5: mode 1 cascades both bytes into one sixteen-bit counter.
// R6: mode 2 low byte overflows, sets flag, reloads from unchanged high byte.
// R7: timer 1 in mode 3 holds its count as if stopped.
// R8: timer 0 mode 3 splits: low byte own controls, high byte uses timer 1's.
// R9: with timer 0 split, timer 1 still counts for baud, raises no flag.
// R10: timer 2 mode: baud if any clock select, else capture, reload or off.
// R11: auto-reload rollover sets overflow flag and loads the reload pair.
// R12: enabled trigger falling edge also reloads and sets external flag.
// R13: capture mode sets overflow flag on every sixteen-bit overflow.
// R14: enabled trigger falling edge captures counter into reload pair, flags.
// R15: baud mode never sets timer 2 overflow flag; external flag still works.
// R16: hardware only sets timer 2 flags; software alone clears them.
// R17: receive clock select picks timer 2 overflows, else timer 1 overflows.
// R18: transmit clock select picks timer 2 overflows, else timer 1 overflows.
// R19: trigger enable allows capture/reload only outside baud mode.
// R20: timer 2 source select counts the count pin, else the core clock.
// R21: in baud mode capture select ignored, overflow always reloads.
// R22: timer 2 control bits: ovf, ext, rx sel, tx sel, trig en, run, src, cap.
// R23: timer 0/1 flags set on overflow, cleared on interrupt vectoring.
// R24: timer 0/1 source select counts the count pin, else system clock.
// R25: two-bit mode field: 00 thirteen, 01 sixteen, 10 reload, 11 split.
// R26: all pins synchronised; falling edges found from successive samples.
module ttc_three_timer_counter_unit
  import ttc_pkg::*;
#(
  parameter int SYS_TICK_DIV = 1,
  parameter int ADDR_W = 12
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_ZERO_COUNT_PIN,
  input wire logic TIMER_ONE_COUNT_PIN,
  input wire logic TIMER_TWO_COUNT_PIN,
  input wire logic TIMER_TWO_TRIGGER_INPUT,
  input wire logic EXTERNAL_LEVEL_INPUT_ZERO,
  input wire logic EXTERNAL_LEVEL_INPUT_ONE,
  input wire logic TIMER_ZERO_VECTOR_ACK,
  input wire logic TIMER_ONE_VECTOR_ACK,
  output logic TIMER_ZERO_OVERFLOW_FLAG,
  output logic TIMER_ONE_OVERFLOW_FLAG,
  output logic TIMER_TWO_OVERFLOW_FLAG,
  output logic TIMER_TWO_EXTERNAL_FLAG,
  output logic RX_BAUD_TICK,
  output logic TX_BAUD_TICK
);

  // ==========================================================================
  // elaboration checks
  localparam int DIV_W = (SYS_TICK_DIV > 1) ? $clog2(SYS_TICK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYS_TICK_DIV - 1);

  if (SYS_TICK_DIV < 1 || SYS_TICK_DIV > 65536) begin : g_bad_div
    $error("SYS_TICK_DIV must lie in 1..65536");
  end
  // the index is PADDR[9:2]; any higher address bit set is refused
  if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie in 10..32 to reach every register");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    logic [PIN_N-1:0] sync1;
    logic [PIN_N-1:0] sync2;
    logic [PIN_N-1:0] prev;
    logic [DIV_W-1:0] div;
    logic [7:0] tmode;
    logic tf1;
    logic tr1;
    logic tf0;
    logic tr0;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] t2ctl;
    logic [7:0] t2_low;
    logic [7:0] t2_high;
    logic [7:0] rc_low;
    logic [7:0] rc_high;
    logic ready;
    logic [7:0] rdata;
    logic slverr;
    logic rx_tick;
    logic tx_tick;
  } ttc_state_t;

  ttc_state_t state_r;
  ttc_state_t state_nxt;

  // ==========================================================================
  // helpers

  // one count step of timer 0/1 in modes 0..2; returns {overflow, high, low}
  function automatic logic [16:0] ttc_step(input ttc_mode_t mode, input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [12:0] v13;
    logic [15:0] v16;
    logic [16:0] res;
    v13 = {hi, lo[4:0]} + 13'h0001;
    v16 = {hi, lo} + 16'h0001;
    res = {1'b0, hi, lo};
    unique case (mode)
      TTC_MODE_13BIT: begin
        // upper three low-byte bits are left alone; software ignores them
        res = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]}; // R1 R2
      end
      TTC_MODE_16BIT: begin
        res = {&{hi, lo}, v16}; // R5 R2
      end
      TTC_MODE_RELOAD: begin
        res = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01}; // R6
      end
      TTC_MODE_SPLIT: begin
        // timer 0 split is handled by the caller; timer 1 just holds
        res = {1'b0, hi, lo}; // R7
      end
    endcase
    return res;
  endfunction : ttc_step

  // read decode; returns {mapped, data}
  function automatic logic [8:0] ttc_read(input logic [7:0] idx, input ttc_state_t s);
    logic [8:0] res;
    res = {1'b1, 8'h00};
    unique case (idx)
      IDX_TIMER_CONTROL: begin
        res[TC_T1_OVF] = s.tf1;
        res[TC_T1_RUN] = s.tr1;
        res[TC_T0_OVF] = s.tf0;
        res[TC_T0_RUN] = s.tr0;
      end
      IDX_TIMER_MODE: res[7:0] = s.tmode;
      IDX_T0_LOW: res[7:0] = s.t0_low;
      IDX_T1_LOW: res[7:0] = s.t1_low;
      IDX_T0_HIGH: res[7:0] = s.t0_high;
      IDX_T1_HIGH: res[7:0] = s.t1_high;
      IDX_T2_CONTROL: res[7:0] = s.t2ctl;
      IDX_RELOAD_LOW: res[7:0] = s.rc_low;
      IDX_RELOAD_HIGH: res[7:0] = s.rc_high;
      IDX_T2_LOW: res[7:0] = s.t2_low;
      IDX_T2_HIGH: res[7:0] = s.t2_high;
      default: res = 9'h000;
    endcase
    return res;
  endfunction : ttc_read

  // ==========================================================================
  // next-state logic
  logic [PIN_N-1:0] fall;
  logic [PIN_N-1:0] lvl;
  logic sys_tick;
  ttc_mode_t mode0;
  ttc_mode_t mode1;
  logic en0;
  logic tk0;
  logic en1;
  logic tk1;
  logic [16:0] step0;
  logic [16:0] step1;
  logic set_tf0;
  logic set_tf1;
  logic t1_ovf;
  logic baud;
  logic tk2;
  logic t2_ovf;
  logic trig;
  logic set_tf2;
  logic set_timer_two_external_flag;
  logic access;
  logic [7:0] widx;
  logic [8:0] rd;
  logic aligned;
  logic wr;
  logic [7:0] wd;

  always_comb begin
    state_nxt = state_r;

    // pins: two flops, then a third sample for edge detection
    // flops clear to zero and idle pins sit high, so release shows a rise
    // and never a false fall
    state_nxt.sync1 = {EXTERNAL_LEVEL_INPUT_ONE, EXTERNAL_LEVEL_INPUT_ZERO,
                       TIMER_TWO_TRIGGER_INPUT, TIMER_TWO_COUNT_PIN,
                       TIMER_ONE_COUNT_PIN, TIMER_ZERO_COUNT_PIN}; // R26
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev = state_r.sync2;
    fall = state_r.prev & ~state_r.sync2; // R26
    lvl = state_r.sync2;

    // system clock enable for the timer-mode sources of timers 0/1
    // with a divider of one the enable is simply high every cycle
    sys_tick = (state_r.div == DIV_LAST);
    state_nxt.div = sys_tick ? '0 : state_r.div + DIV_W'(1);

    mode0 = ttc_mode_t'(state_r.tmode[TM_T0_LSB+TM_MODE_HI -: 2]); // R25
    mode1 = ttc_mode_t'(state_r.tmode[TM_T1_LSB+TM_MODE_HI -: 2]); // R25

    // ---- timer 0
    en0 = state_r.tr0 & (~state_r.tmode[TM_T0_LSB+TM_QUALIFY] | lvl[PIN_LVL0]); // R3
    tk0 = state_r.tmode[TM_T0_LSB+TM_SOURCE] ? fall[PIN_T0] : sys_tick; // R24
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    step0 = ttc_step(mode0, state_r.t0_high, state_r.t0_low);
    if (mode0 == TTC_MODE_SPLIT) begin
      if (en0 && tk0) begin
        state_nxt.t0_low = state_r.t0_low + 8'h01; // R8
        set_tf0 = &state_r.t0_low; // R8 R2
      end
      // high byte borrows timer 1's run bit and flag, counting system ticks
      if (state_r.tr1 && sys_tick) begin
        state_nxt.t0_high = state_r.t0_high + 8'h01; // R8
        set_tf1 = &state_r.t0_high; // R8
      end
    end else if (en0 && tk0) begin
      {set_tf0, state_nxt.t0_high, state_nxt.t0_low} = step0; // R2
    end

    // ---- timer 1
    en1 = state_r.tr1 & (~state_r.tmode[TM_T1_LSB+TM_QUALIFY] | lvl[PIN_LVL1])
          & (mode1 != TTC_MODE_SPLIT); // R3 R7
    tk1 = state_r.tmode[TM_T1_LSB+TM_SOURCE] ? fall[PIN_T1] : sys_tick; // R24
    step1 = ttc_step(mode1, state_r.t1_high, state_r.t1_low);
    t1_ovf = 1'b0;
    if (en1 && tk1) begin
      {t1_ovf, state_nxt.t1_high, state_nxt.t1_low} = step1;
    end
    // split timer 0 owns the flag; timer 1 still feeds the baud ticks
    if (mode0 != TTC_MODE_SPLIT) begin
      set_tf1 = set_tf1 | t1_ovf; // R2 R9
    end

    // ---- timer 2
    baud = state_r.t2ctl[T2_RX_SEL] | state_r.t2ctl[T2_TX_SEL]; // R10
    tk2 = state_r.t2ctl[T2_SOURCE] ? fall[PIN_T2] : 1'b1; // R20
    // the enable alone qualifies the edge; run and baud only steer its effect
    trig = fall[PIN_TRIG] & state_r.t2ctl[T2_TRIG_EN]; // R19
    t2_ovf = 1'b0;
    set_tf2 = 1'b0;
    set_timer_two_external_flag = 1'b0;
    if (state_r.t2ctl[T2_RUN] && tk2) begin // R10
      {state_nxt.t2_high, state_nxt.t2_low} = {state_r.t2_high, state_r.t2_low} + 16'h0001;
      // overflow is judged on the old count; a same-cycle write still wins
      if (&{state_r.t2_high, state_r.t2_low}) begin
        t2_ovf = 1'b1;
        set_tf2 = ~baud; // R13 R11 R15
        if (baud || !state_r.t2ctl[T2_CAPTURE]) begin
          state_nxt.t2_low = state_r.rc_low; // R11 R21
          state_nxt.t2_high = state_r.rc_high; // R11 R21
        end
      end
    end
    if (trig) begin
      // in baud mode the edge is only an extra interrupt source
      set_timer_two_external_flag = 1'b1; // R15 R16
      if (state_r.t2ctl[T2_RUN] && !baud) begin // R19
        if (state_r.t2ctl[T2_CAPTURE]) begin
          state_nxt.rc_low = state_r.t2_low; // R14
          state_nxt.rc_high = state_r.t2_high; // R14
        end else begin
          state_nxt.t2_low = state_r.rc_low; // R12
          state_nxt.t2_high = state_r.rc_high; // R12
        end
      end
    end
    state_nxt.rx_tick = state_r.t2ctl[T2_RX_SEL] ? t2_ovf : t1_ovf; // R17
    state_nxt.tx_tick = state_r.t2ctl[T2_TX_SEL] ? t2_ovf : t1_ovf; // R18

    // ---- APB slave: one wait state, answer registered
    // error and read data settle in the first access cycle, so both stand
    // with ready and hold until the next answer
    access = PSEL & PENABLE;
    widx = PADDR[9:2];
    aligned = (PADDR[1:0] == 2'b00) && (ADDR_W == 10 || (PADDR >> 10) == '0);
    rd = ttc_read(widx, state_r);
    state_nxt.ready = access & ~state_r.ready;
    if (access && !state_r.ready) begin
      state_nxt.slverr = ~(aligned & rd[8]);
      state_nxt.rdata = (aligned && !PWRITE) ? rd[7:0] : 8'h00;
    end
    wr = access & state_r.ready & PWRITE & PSTRB[0] & aligned & rd[8];
    wd = PWDATA[7:0];

    // software writes win over counting in the same cycle
    // only byte lane 0 carries a register; upper lanes are ignored
    if (wr) begin
      unique case (widx)
        IDX_TIMER_MODE: state_nxt.tmode = wd;
        IDX_TIMER_CONTROL: begin
          state_nxt.tr1 = wd[TC_T1_RUN]; // R4
          state_nxt.tr0 = wd[TC_T0_RUN]; // R4
        end
        IDX_T0_LOW: state_nxt.t0_low = wd;
        IDX_T1_LOW: state_nxt.t1_low = wd;
        IDX_T0_HIGH: state_nxt.t0_high = wd;
        IDX_T1_HIGH: state_nxt.t1_high = wd;
        IDX_T2_CONTROL: state_nxt.t2ctl[T2_RX_SEL:0] = wd[T2_RX_SEL:0]; // R22
        IDX_RELOAD_LOW: state_nxt.rc_low = wd;
        IDX_RELOAD_HIGH: state_nxt.rc_high = wd;
        IDX_T2_LOW: state_nxt.t2_low = wd;
        IDX_T2_HIGH: state_nxt.t2_high = wd;
        default: state_nxt.tmode = state_r.tmode;
      endcase
    end

    // ---- flags: a hardware set always wins over any clear in the same cycle
    // so an overflow that meets a vector acknowledge is never lost
    state_nxt.tf0 = ((wr && widx == IDX_TIMER_CONTROL) ? wd[TC_T0_OVF] : state_r.tf0)
                    & ~TIMER_ZERO_VECTOR_ACK | set_tf0; // R23 R2
    state_nxt.tf1 = ((wr && widx == IDX_TIMER_CONTROL) ? wd[TC_T1_OVF] : state_r.tf1)
                    & ~TIMER_ONE_VECTOR_ACK | set_tf1; // R23 R2
    state_nxt.t2ctl[T2_OVF] = ((wr && widx == IDX_T2_CONTROL) ? wd[T2_OVF]
                              : state_r.t2ctl[T2_OVF]) | set_tf2; // R16
    state_nxt.t2ctl[T2_EXT] = ((wr && widx == IDX_T2_CONTROL) ? wd[T2_EXT]
                              : state_r.t2ctl[T2_EXT]) | set_timer_two_external_flag; // R16
  end

  // ==========================================================================
  // state register
  // count bytes have no fixed power-on value; zero keeps runs repeatable
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_r <= '0;
      state_r.tmode <= RST_TIMER_MODE;
      state_r.t2ctl <= RST_T2_CONTROL;
      state_r.t0_low <= RST_COUNT;
      state_r.t0_high <= RST_COUNT;
      state_r.t1_low <= RST_COUNT;
      state_r.t1_high <= RST_COUNT;
      state_r.t2_low <= RST_COUNT;
      state_r.t2_high <= RST_COUNT;
      state_r.rc_low <= RST_COUNT;
      state_r.rc_high <= RST_COUNT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign PRDATA = {24'h000000, state_r.rdata};
  assign PREADY = state_r.ready;
  assign PSLVERR = state_r.slverr;
  assign TIMER_ZERO_OVERFLOW_FLAG = state_r.tf0;
  assign TIMER_ONE_OVERFLOW_FLAG = state_r.tf1;
  assign TIMER_TWO_OVERFLOW_FLAG = state_r.t2ctl[T2_OVF];
  assign TIMER_TWO_EXTERNAL_FLAG = state_r.t2ctl[T2_EXT];
  assign RX_BAUD_TICK = state_r.rx_tick;
  assign TX_BAUD_TICK = state_r.tx_tick;

endmodule : ttc_three_timer_counter_unit

`default_nettype wire

// File: ttc_pin_model.sv
// ttc_pin_model: far side of the timer unit, driving count, trigger and level pins
// assumes: tasks are called from the bench on the unit's clock; pins idle high
`timescale 1ns/10ps
`default_nettype none
module ttc_pin_model
  import ttc_pkg::*;
(
  input wire logic sys_clk,
  output logic [PIN_N-1:0] pins
);
  initial pins = '1;
  // ======
  // pulses
  // len sets how slowly the far side answers; 3 or more clears the synchroniser
  task automatic pulse(input int idx, input int len);
    @(posedge sys_clk);
    pins[idx] <= 1'b0;
    repeat (len) @(posedge sys_clk);
    pins[idx] <= 1'b1;
    repeat (len) @(posedge sys_clk);
  endtask : pulse
  task automatic level(input int idx, input logic v);
    @(posedge sys_clk);
    pins[idx] <= v;
    repeat (4) @(posedge sys_clk);
  endtask : level
endmodule : ttc_pin_model
`default_nettype wire

// File: ttc_unit_assertions.sv
// ttc_unit_assertions: port-level checker for the timer unit
// assumes: bound to ttc_three_timer_counter_unit, one clock domain
`timescale 1ns/10ps
`default_nettype none
module ttc_unit_assertions #(
  parameter int ADDR_W = 12
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TIMER_TWO_TRIGGER_INPUT,
  input wire logic TIMER_ZERO_VECTOR_ACK,
  input wire logic TIMER_ZERO_OVERFLOW_FLAG,
  input wire logic TIMER_TWO_OVERFLOW_FLAG,
  input wire logic TIMER_TWO_EXTERNAL_FLAG
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  // ======
  // helpers
  logic trig_q;
  logic [3:0] trig_age;
  logic wr_t2;
  logic wr_tc;
  assign wr_t2 = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR[9:0] == 10'h320;
  assign wr_tc = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && PADDR[9:0] == 10'h220;
  // age of the last trigger fall, saturating so old edges never excuse a flag
  always_ff @(posedge SYS_CLK) begin
    trig_q <= TIMER_TWO_TRIGGER_INPUT;
    if (!NRST)
      trig_age <= 4'hF;
    else if (trig_q && !TIMER_TWO_TRIGGER_INPUT)
      trig_age <= 4'h0;
    else if (trig_age != 4'hF)
      trig_age <= trig_age + 4'h1;
  end
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence
  // ======
  // properties
  chk_one_wait: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  chk_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_misalign_err: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR && PRDATA == 32'h0)
    else $error("misaligned access not refused");
  chk_ovf_sticky: assert property ($fell(TIMER_TWO_OVERFLOW_FLAG) |-> $past(wr_t2))
    else $error("timer two overflow flag cleared without write");
  chk_ext_sticky: assert property ($fell(TIMER_TWO_EXTERNAL_FLAG) |-> $past(wr_t2))
    else $error("external flag cleared without write");
  chk_t0_clear: assert property (
    $fell(TIMER_ZERO_OVERFLOW_FLAG) |-> $past(TIMER_ZERO_VECTOR_ACK || wr_tc))
    else $error("timer zero flag cleared without cause");
  chk_ext_cause: assert property (
    $rose(TIMER_TWO_EXTERNAL_FLAG) |-> trig_age <= 4'h8 || $past(wr_t2))
    else $error("external flag set without trigger edge");
endmodule : ttc_unit_assertions
bind ttc_three_timer_counter_unit ttc_unit_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TIMER_TWO_TRIGGER_INPUT(TIMER_TWO_TRIGGER_INPUT),
  .TIMER_ZERO_VECTOR_ACK(TIMER_ZERO_VECTOR_ACK),
  .TIMER_ZERO_OVERFLOW_FLAG(TIMER_ZERO_OVERFLOW_FLAG),
  .TIMER_TWO_OVERFLOW_FLAG(TIMER_TWO_OVERFLOW_FLAG),
  .TIMER_TWO_EXTERNAL_FLAG(TIMER_TWO_EXTERNAL_FLAG));
`default_nettype wire

// File: tb.sv
// tb: self-checking bench for the three-timer counter unit
// assumes: ttc_pin_model plays the pins; the checker is bound separately
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ttc_pkg::*;
  logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, ack0, ack1;
  logic f0, f1, f2, fx, rxt, txt;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [PIN_N-1:0] pins;
  logic [9:0] exp_q[$];
  logic [9:0] note;
  logic [15:0] lfsr = 16'h2FF4;
  int n_errors = 0;
  int checked = 0;
  int rx_n = 0;
  int tx_n = 0;
  int rx0, tx0;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  ttc_pin_model pm (.sys_clk(sys_clk), .pins(pins));
  ttc_three_timer_counter_unit #(.SYS_TICK_DIV(1), .ADDR_W(12)) dut (
    .SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TIMER_ZERO_COUNT_PIN(pins[PIN_T0]), .TIMER_ONE_COUNT_PIN(pins[PIN_T1]),
    .TIMER_TWO_COUNT_PIN(pins[PIN_T2]), .TIMER_TWO_TRIGGER_INPUT(pins[PIN_TRIG]),
    .EXTERNAL_LEVEL_INPUT_ZERO(pins[PIN_LVL0]), .EXTERNAL_LEVEL_INPUT_ONE(pins[PIN_LVL1]),
    .TIMER_ZERO_VECTOR_ACK(ack0), .TIMER_ONE_VECTOR_ACK(ack1),
    .TIMER_ZERO_OVERFLOW_FLAG(f0), .TIMER_ONE_OVERFLOW_FLAG(f1), .TIMER_TWO_OVERFLOW_FLAG(f2),
    .TIMER_TWO_EXTERNAL_FLAG(fx), .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt));
  // ======
  // checking
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // note: [9] read data checked, [8] error expected, [7:0] data
  always @(posedge sys_clk) begin
    if (pready === 1'b1) begin
      note = exp_q.pop_front();
      cmp("pslverr", {7'h0, note[8]}, {7'h0, pslverr});
      if (note[9])
        cmp("prdata", note[7:0], prdata[7:0]);
    end
    if (rxt === 1'b1)
      rx_n++;
    if (txt === 1'b1)
      tx_n++;
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
  // ======
  // bus master
  task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] d,
      input logic [9:0] nt);
    int n;
    exp_q.push_back(nt);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb({2'b00, i, 2'b00}, 1'b1, d, 10'h000);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    apb({2'b00, i, 2'b00}, 1'b0, 8'h00, {2'b10, e});
  endtask : rd
  // one timer 0/1 case: preload, start, one pin fall, read back
  task automatic tcase(input logic [7:0] li, hi_i, md, h, l, input int pin,
      input logic [7:0] ctl, eh, el, ec);
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_TIMER_MODE, md);
    wr(hi_i, h);
    wr(li, l);
    wr(IDX_TIMER_CONTROL, ctl);
    rd(li, l);
    pm.pulse(pin, 3);
    rd(hi_i, eh);
    rd(li, el);
    rd(IDX_TIMER_CONTROL, ec);
    cmp("t0 flag", {7'h0, ec[TC_T0_OVF]}, {7'h0, f0});
    cmp("t1 flag", {7'h0, ec[TC_T1_OVF]}, {7'h0, f1});
    $display("test timer case mode %h ends", md);
  endtask : tcase
  // ======
  // main sequence
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ack0 = 1'b0;
    ack1 = 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(IDX_T2_CONTROL, RST_T2_CONTROL);
    rd(IDX_TIMER_MODE, RST_TIMER_MODE);
    rd(IDX_T0_LOW, RST_COUNT);
    apb(12'h000, 1'b0, 8'h00, 10'h300);
    apb(12'h221, 1'b1, 8'hFF, 10'h100);
    $display("test reset and refusals ends");
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h05, 8'hFF, 8'hFF, PIN_T0, 8'h10, 8'h00, 8'h00,
      8'h30);
    @(posedge sys_clk);
    ack0 <= 1'b1;
    @(posedge sys_clk);
    ack0 <= 1'b0;
    rd(IDX_TIMER_CONTROL, 8'h10);
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h05, lfsr[7:0], 8'hFF, PIN_T0, 8'h10, lfsr[7:0] + 8'h01,
        8'h00, lfsr[7:0] == 8'hFF ? 8'h30 : 8'h10);
    end
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h04, 8'h00, 8'hFF, PIN_T0, 8'h10, 8'h01, 8'hE0,
      8'h10);
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h04, 8'hFF, 8'h1F, PIN_T0, 8'h10, 8'h00, 8'h00,
      8'h30);
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h06, 8'h80, 8'hFF, PIN_T0, 8'h10, 8'h80, 8'h80, 8'h30);
    rx0 = rx_n;
    tcase(IDX_T1_LOW, IDX_T1_HIGH, 8'h60, 8'h80, 8'hFF, PIN_T1, 8'h40, 8'h80, 8'h80, 8'hC0);
    cmp("rx ticks t1", 8'h01, 8'(rx_n - rx0));
    @(posedge sys_clk);
    ack1 <= 1'b1;
    @(posedge sys_clk);
    ack1 <= 1'b0;
    rd(IDX_TIMER_CONTROL, 8'h40);
    tcase(IDX_T1_LOW, IDX_T1_HIGH, 8'h70, 8'h00, 8'h10, PIN_T1, 8'h40, 8'h00, 8'h10, 8'h40);
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h07, 8'h00, 8'hFF, PIN_T0, 8'h10, 8'h00, 8'h00, 8'h30);
    pm.level(PIN_LVL0, 1'b0);
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h0D, 8'h00, 8'h05, PIN_T0, 8'h10, 8'h00, 8'h05, 8'h10);
    pm.level(PIN_LVL0, 1'b1);
    tcase(IDX_T0_LOW, IDX_T0_HIGH, 8'h0D, 8'h00, 8'h05, PIN_T0, 8'h10, 8'h00, 8'h06, 8'h10);
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_RELOAD_LOW, 8'h34);
    wr(IDX_RELOAD_HIGH, 8'h12);
    wr(IDX_T2_LOW, 8'hFF);
    wr(IDX_T2_HIGH, 8'hFF);
    wr(IDX_T2_CONTROL, 8'h06);
    pm.pulse(PIN_T2, 5);
    rd(IDX_T2_LOW, 8'h34);
    rd(IDX_T2_HIGH, 8'h12);
    rd(IDX_T2_CONTROL, 8'h86);
    cmp("t2 flag", 8'h01, {7'h0, f2});
    wr(IDX_T2_CONTROL, 8'h06);
    wr(IDX_T2_LOW, 8'h00);
    pm.pulse(PIN_TRIG, 3);
    rd(IDX_T2_CONTROL, 8'h06);
    rd(IDX_T2_LOW, 8'h00);
    wr(IDX_T2_CONTROL, 8'h0E);
    pm.pulse(PIN_TRIG, 4);
    rd(IDX_T2_LOW, 8'h34);
    rd(IDX_T2_CONTROL, 8'h4E);
    cmp("ext flag", 8'h01, {7'h0, fx});
    $display("test timer two reload ends");
    wr(IDX_T2_CONTROL, 8'h0F);
    wr(IDX_T2_LOW, 8'h55);
    wr(IDX_T2_HIGH, 8'h66);
    pm.pulse(PIN_TRIG, 3);
    rd(IDX_RELOAD_LOW, 8'h55);
    rd(IDX_RELOAD_HIGH, 8'h66);
    rd(IDX_T2_CONTROL, 8'h4F);
    wr(IDX_T2_LOW, 8'hFF);
    wr(IDX_T2_HIGH, 8'hFF);
    pm.pulse(PIN_T2, 3);
    rd(IDX_T2_LOW, 8'h00);
    rd(IDX_T2_CONTROL, 8'hCF);
    $display("test timer two capture ends");
    wr(IDX_T2_CONTROL, 8'h37);
    wr(IDX_T2_LOW, 8'hFF);
    wr(IDX_T2_HIGH, 8'hFF);
    rx0 = rx_n;
    tx0 = tx_n;
    pm.pulse(PIN_T2, 3);
    rd(IDX_T2_HIGH, 8'h66);
    rd(IDX_T2_CONTROL, 8'h37);
    cmp("t2 flag", 8'h00, {7'h0, f2});
    cmp("rx ticks", 8'h01, 8'(rx_n - rx0));
    cmp("tx ticks", 8'h01, 8'(tx_n - tx0));
    wr(IDX_T2_CONTROL, 8'h3F);
    wr(IDX_T2_LOW, 8'h11);
    pm.pulse(PIN_TRIG, 3);
    rd(IDX_RELOAD_LOW, 8'h55);
    rd(IDX_T2_CONTROL, 8'h7F);
    $display("test baud ends");
    repeat (4) @(posedge sys_clk);
    cmp("pending notes", 8'h00, 8'(exp_q.size()));
    finish_test();
  end
endmodule : tb
`default_nettype wire
